// ===== rtl/sps_pkg.sv
// Package for the byte-wide serial port: register map, field positions, reset values.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package sps_pkg;
    // Register byte addresses.
    localparam logic [7:0] SPS_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] SPS_STAT_ADDR   = 8'h04;
    localparam logic [7:0] SPS_DATA_ADDR   = 8'h08;
    localparam logic [7:0] SPS_PWR_ADDR    = 8'h0C;
    localparam logic [7:0] SPS_PINDIR_ADDR = 8'h10;
    // Control register fields.
    localparam int SPS_CTRL_RATE_LSB = 0;
    localparam int SPS_CTRL_PHASE    = 2;
    localparam int SPS_CTRL_POLAR    = 3;
    localparam int SPS_CTRL_MASTER   = 4;
    localparam int SPS_CTRL_LSBF     = 5;
    localparam int SPS_CTRL_EN       = 6;
    localparam int SPS_CTRL_IRQEN    = 7;
    // Status register fields.
    localparam int SPS_STAT_DBL  = 0;
    localparam int SPS_STAT_WRITE_COLLISION_FLAG = 6;
    localparam int SPS_STAT_DONE = 7;
    // Pin direction register fields (software output enables).
    localparam int SPS_DIR_MOSI = 0;
    localparam int SPS_DIR_MISO = 1;
    localparam int SPS_DIR_SCK  = 2;
    localparam int SPS_DIR_SS   = 3;
    // Reset values.
    localparam logic [7:0] SPS_CTRL_RST   = 8'h00;
    localparam logic       SPS_PWR_RST    = 1'b1;
    localparam logic [3:0] SPS_PINDIR_RST = 4'h0;
    // Bits in one byte.
    localparam logic [3:0] SPS_BYTE_BITS  = 4'h8;
    typedef enum logic [2:0] {
        SPS_IDLE  = 3'b001,
        SPS_LEAD  = 3'b010,
        SPS_TRAIL = 3'b100
    } sps_state_t;
endpackage : sps_pkg

// ===== rtl/sps_port.sv
// Byte-wide SPI master/slave port with APB register access.
// Assumes pin inputs are asynchronous; a pad wrapper resolves the enables.
// What this block does
// - Port idle while power gate bit set.
// - MOSI master-to-slave, MISO slave-to-master.
// - Master mode leaves select to software.
// - Master data write starts byte shift.
// - Clock halts, done flag set after byte.
// - Done flag with enable raises interrupt.
// - Master sends further bytes after completion.
// - Last received byte kept for reading.
// - Slave idle, MISO undriven while select high.
// - Slave ignores SCK until select low.
// - Slave sets done flag after full byte.
// - Slave may load next byte early.
// - Single transmit buffer; no write mid-transfer.
// - Double receive buffer; late read loses byte.
// - Pin directions overridden per mode.
// - LSB-first or MSB-first selectable.
// - Seven master rates including divide-by-two.
// - Write collision flag reports illegal write.
// - Busy data write sets collision; status-then-data clears.
// - Done clears on vector taken or status-then-data.
// - Slave select rising resets shift logic.
// - Master with select input low becomes slave.
//
// The address map and the APB register port are this design's own decisions.
module sps_port (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Interrupt handshake
    input  wire logic        i_irq_ack,
    output logic             o_irq,
    // Serial pins
    input  wire logic        i_sck,
    input  wire logic        i_mosi,
    input  wire logic        i_miso,
    input  wire logic        i_ss_b,
    output logic             o_sck,
    output logic             o_sck_oe,
    output logic             o_mosi,
    output logic             o_mosi_oe,
    output logic             o_miso,
    output logic             o_miso_oe,
    output logic             o_ss_b_oe
);
    logic [7:0] ctrl_reg;
    logic       dbl_reg;
    logic       pwr_gate_reg;
    logic [3:0] pindir_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_buf_reg;
    logic       done_reg;
    logic       write_collision_flag_reg;
    logic       stat_seen_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] div_reg;
    logic       sample_reg;
    sps_pkg::sps_state_t state_reg;
    logic [2:0] sck_sync_reg;
    logic [1:0] ss_sync_reg;
    logic [2:0] mosi_sync_reg;
    logic [1:0] miso_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers. Stage 0 feeds only stage 1.
    always_ff @(posedge i_mclk) begin
        sck_sync_reg  <= {sck_sync_reg[1:0], i_sck};
        ss_sync_reg   <= {ss_sync_reg[0], i_ss_b};
        mosi_sync_reg <= {mosi_sync_reg[1:0], i_mosi};
        miso_sync_reg <= {miso_sync_reg[0], i_miso};
    end

    logic enabled, master, ss_low, sck_s, sck_p, mosi_s, miso_s;
    assign sck_s  = sck_sync_reg[1];
    assign sck_p  = sck_sync_reg[2];
    assign mosi_s = mosi_sync_reg[1];
    assign miso_s = miso_sync_reg[1];
    assign ss_low = ~ss_sync_reg[1];
    assign enabled = ctrl_reg[sps_pkg::SPS_CTRL_EN] & ~pwr_gate_reg;
    assign master  = ctrl_reg[sps_pkg::SPS_CTRL_MASTER];

    ////////////////////////////////////////////////////////////////////////////
    // APB decode. Zero wait states; unmapped addresses answer with pslverr.
    logic acc, wr, rd, hit_data, hit_stat, mapped;
    assign acc      = i_psel & i_penable;
    assign wr       = acc & i_pwrite;
    assign rd       = acc & ~i_pwrite;
    assign hit_data = i_paddr == sps_pkg::SPS_DATA_ADDR;
    assign hit_stat = i_paddr == sps_pkg::SPS_STAT_ADDR;
    assign mapped   = hit_data | hit_stat | (i_paddr == sps_pkg::SPS_CTRL_ADDR)
                    | (i_paddr == sps_pkg::SPS_PWR_ADDR)
                    | (i_paddr == sps_pkg::SPS_PINDIR_ADDR);

    logic busy;
    assign busy = state_reg != sps_pkg::SPS_IDLE;

    logic [7:0] stat_val;
    assign stat_val = {done_reg, write_collision_flag_reg, 5'h00, dbl_reg};

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= i_psel & ~i_penable & ~(i_paddr == sps_pkg::SPS_CTRL_ADDR
                         | i_paddr == sps_pkg::SPS_STAT_ADDR
                         | i_paddr == sps_pkg::SPS_DATA_ADDR
                         | i_paddr == sps_pkg::SPS_PWR_ADDR
                         | i_paddr == sps_pkg::SPS_PINDIR_ADDR);
            o_prdata  <= 32'h0000_0000;
            if (i_psel & ~i_penable & ~i_pwrite) begin
                case (i_paddr)
                    sps_pkg::SPS_CTRL_ADDR:   o_prdata <= {24'h00_0000, ctrl_reg};
                    sps_pkg::SPS_STAT_ADDR:   o_prdata <= {24'h00_0000, stat_val};
                    sps_pkg::SPS_DATA_ADDR:   o_prdata <= {24'h00_0000, rx_buf_reg};
                    sps_pkg::SPS_PWR_ADDR:    o_prdata <= {31'h0000_0000, pwr_gate_reg};
                    sps_pkg::SPS_PINDIR_ADDR: o_prdata <= {28'h000_0000, pindir_reg};
                    default:                  o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Ready is high in every access phase: one setup plus one access cycle.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= i_psel & ~i_penable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers.
    logic mode_fault;
    assign mode_fault = enabled & master & ~pindir_reg[sps_pkg::SPS_DIR_SS] & ss_low;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ctrl_reg     <= sps_pkg::SPS_CTRL_RST;
            dbl_reg      <= 1'b0;
            pwr_gate_reg <= sps_pkg::SPS_PWR_RST;
            pindir_reg   <= sps_pkg::SPS_PINDIR_RST;
        end else begin
            if (wr & (i_paddr == sps_pkg::SPS_CTRL_ADDR)) begin
                ctrl_reg <= i_pwdata[7:0];
            end else if (mode_fault) begin
                ctrl_reg[sps_pkg::SPS_CTRL_MASTER] <= 1'b0;
            end
            if (wr & hit_stat) begin
                dbl_reg <= i_pwdata[sps_pkg::SPS_STAT_DBL];
            end
            if (wr & (i_paddr == sps_pkg::SPS_PWR_ADDR)) begin
                pwr_gate_reg <= i_pwdata[0];
            end
            if (wr & (i_paddr == sps_pkg::SPS_PINDIR_ADDR)) begin
                pindir_reg <= i_pwdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master clock divider. Half-period in clocks for each rate code.
    // The MISO synchroniser costs two cycles, so the two fastest rates suit only quick slaves.
    // seven rate choices
    logic [6:0] half_per;
    always_comb begin
        case ({dbl_reg, ctrl_reg[sps_pkg::SPS_CTRL_RATE_LSB +: 2]})
            3'b000:  half_per = 7'h02;
            3'b001:  half_per = 7'h08;
            3'b010:  half_per = 7'h20;
            3'b011:  half_per = 7'h40;
            3'b100:  half_per = 7'h01;
            3'b101:  half_per = 7'h04;
            3'b110:  half_per = 7'h10;
            default: half_per = 7'h20;
        endcase
    end

    logic half_tick;
    assign half_tick = div_reg == (half_per - 7'h01);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || state_reg == sps_pkg::SPS_IDLE || half_tick) begin
            div_reg <= 7'h00;
        end else begin
            div_reg <= div_reg + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge sources: generated half periods in master, synchronised SCK in slave.
    logic cpol, cpha, lsbf, lead_edge, trail_edge, slave_act, start;
    assign cpol = ctrl_reg[sps_pkg::SPS_CTRL_POLAR];
    assign cpha = ctrl_reg[sps_pkg::SPS_CTRL_PHASE];
    assign lsbf = ctrl_reg[sps_pkg::SPS_CTRL_LSBF];
    assign slave_act = enabled & ~master & ss_low;
    assign lead_edge  = master ? (state_reg == sps_pkg::SPS_LEAD & half_tick)
                               : (slave_act & (sck_s ^ sck_p) & (sck_s ^ cpol));
    assign trail_edge = master ? (state_reg == sps_pkg::SPS_TRAIL & half_tick)
                               : (slave_act & (sck_s ^ sck_p) & ~(sck_s ^ cpol));
    assign start = wr & hit_data & ~busy;

    logic do_sample, do_setup, byte_done, rx_bit;
    assign do_sample = cpha ? trail_edge : lead_edge;
    assign do_setup  = cpha ? lead_edge : trail_edge;
    assign rx_bit    = master ? miso_s : mosi_s;
    assign byte_done = do_sample & (bit_cnt_reg == sps_pkg::SPS_BYTE_BITS - 4'h1);

    ////////////////////////////////////////////////////////////////////////////
    // Transfer state: idle, leading half, trailing half.
    logic ss_rise;
    assign ss_rise = ~master & ~ss_low;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || !enabled || mode_fault || (ss_rise && busy)) begin
            state_reg <= sps_pkg::SPS_IDLE;
        end else begin
            case (state_reg)
                sps_pkg::SPS_IDLE: begin
                    if (master & start) begin
                        state_reg <= sps_pkg::SPS_LEAD;
                    end else if (slave_act & (sck_s ^ sck_p)) begin
                        state_reg <= sck_s ^ cpol ? sps_pkg::SPS_TRAIL : sps_pkg::SPS_LEAD;
                    end
                end
                sps_pkg::SPS_LEAD: begin
                    if (lead_edge) begin
                        state_reg <= sps_pkg::SPS_TRAIL;
                    end
                end
                sps_pkg::SPS_TRAIL: begin
                    if (trail_edge) begin
                        state_reg <= (bit_cnt_reg == sps_pkg::SPS_BYTE_BITS) | byte_done
                                   ? sps_pkg::SPS_IDLE : sps_pkg::SPS_LEAD;
                    end
                end
                default: state_reg <= sps_pkg::SPS_IDLE;
            endcase
        end
    end

    // Bit counter and sample holding bit.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || state_reg == sps_pkg::SPS_IDLE && !slave_act) begin
            bit_cnt_reg <= 4'h0;
            sample_reg  <= 1'b0;
        end else if (do_sample) begin
            bit_cnt_reg <= bit_cnt_reg == sps_pkg::SPS_BYTE_BITS ? 4'h1 : bit_cnt_reg + 4'h1;
            sample_reg  <= rx_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift register and receive buffer.
    // slave loads early
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            shift_reg  <= 8'h00;
            rx_buf_reg <= 8'h00;
        end else begin
            if (start) begin
                shift_reg <= i_pwdata[7:0];
            end else if (do_setup & bit_cnt_reg != 4'h0) begin
                shift_reg <= lsbf ? {sample_reg, shift_reg[7:1]} : {shift_reg[6:0], sample_reg};
            end
            if (byte_done) begin
                rx_buf_reg <= lsbf ? {rx_bit, shift_reg[7:1]} : {shift_reg[6:0], rx_bit};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags. Hardware set wins over the status-then-data clear.
    logic flag_clear;
    assign flag_clear = stat_seen_reg & acc & hit_data;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            done_reg      <= 1'b0;
            write_collision_flag_reg      <= 1'b0;
            stat_seen_reg <= 1'b0;
        end else begin
            if (rd & hit_stat) begin
                stat_seen_reg <= done_reg | write_collision_flag_reg;
            end else if (acc & hit_data) begin
                stat_seen_reg <= 1'b0;
            end
            if (byte_done | mode_fault) begin
                done_reg <= 1'b1;
            end else if (flag_clear | i_irq_ack) begin
                done_reg <= 1'b0;
            end
            if (wr & hit_data & busy) begin
                write_collision_flag_reg <= 1'b1;
            end else if (flag_clear) begin
                write_collision_flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered.
    logic tx_bit, sck_level;
    assign tx_bit    = lsbf ? shift_reg[0] : shift_reg[7];
    assign sck_level = cpol ^ (state_reg == sps_pkg::SPS_TRAIL);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_irq     <= 1'b0;
            o_sck     <= 1'b0;
            o_mosi    <= 1'b0;
            o_miso    <= 1'b0;
            o_sck_oe  <= 1'b0;
            o_mosi_oe <= 1'b0;
            o_miso_oe <= 1'b0;
            o_ss_b_oe <= 1'b0;
        end else begin
            o_irq     <= done_reg & ctrl_reg[sps_pkg::SPS_CTRL_IRQEN];
            o_sck     <= master ? sck_level : cpol;
            o_mosi    <= tx_bit;
            o_miso    <= tx_bit;
            o_sck_oe  <= pindir_reg[sps_pkg::SPS_DIR_SCK] & (~enabled | master);
            o_mosi_oe <= pindir_reg[sps_pkg::SPS_DIR_MOSI] & (~enabled | master);
            o_ss_b_oe <= pindir_reg[sps_pkg::SPS_DIR_SS] & (~enabled | master);
            o_miso_oe <= pindir_reg[sps_pkg::SPS_DIR_MISO] & enabled & ~master & ss_low;
        end
    end
endmodule : sps_port

// ===== bench/sps_port_sva.sv
// Checker for the serial port: APB, interrupt and pin relations.
// Assumes mode 0 traffic: clock idles low and data is sampled on its rise.
module sps_port_sva (
    // Clock and reset
    input wire logic        i_mclk,
    input wire logic        i_rst_b,
    // APB and interrupt
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        i_irq_ack,
    input wire logic        o_irq,
    // Serial pins
    input wire logic        i_ss_b,
    input wire logic        o_sck,
    input wire logic        o_sck_oe,
    input wire logic        o_mosi,
    input wire logic        o_mosi_oe,
    input wire logic        o_miso_oe,
    input wire logic        o_ss_b_oe
);
    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    logic       pwr_on_reg;
    logic       ien_reg;
    logic       sck_q_reg;
    logic       irq_q_reg;
    logic [3:0] edge_cnt_reg;
    logic       acc_wr;
    logic [3:0] edge_tot;
    assign acc_wr   = i_psel && i_penable && i_pwrite;
    assign edge_tot = edge_cnt_reg + {3'h0, o_sck && !sck_q_reg};
    ////////////////////////////////////////////////////////////////////////
    // Shadows of software settings, taken at the APB access edge.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            pwr_on_reg <= 1'b0;
        end else if (acc_wr && i_paddr == sps_pkg::SPS_PWR_ADDR) begin
            pwr_on_reg <= !i_pwdata[0];
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ien_reg <= 1'b0;
        end else if (acc_wr && i_paddr == sps_pkg::SPS_CTRL_ADDR) begin
            ien_reg <= i_pwdata[sps_pkg::SPS_CTRL_IRQEN];
        end
    end
    always_ff @(posedge i_mclk) begin
        sck_q_reg <= i_rst_b && o_sck;
        irq_q_reg <= i_rst_b && o_irq;
    end
    // Rising clock edges since the last interrupt; the rise itself restarts it.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || (o_irq && !irq_q_reg)) begin
            edge_cnt_reg <= 4'h0;
        end else if (o_sck && !sck_q_reg) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    AST_PWR_GATE: assert property (!pwr_on_reg |-> $stable(o_sck) && !o_irq)
        else $error("serial clock or interrupt while power gated");
    AST_MOSI_HOLD: assert property (o_mosi_oe && o_sck && $past(o_sck) |-> $stable(o_mosi))
        else $error("mosi moved during clock high phase");
    AST_EIGHT_EDGES: assert property ($rose(o_irq) && o_sck_oe |-> edge_tot == 4'h8)
        else $error("byte did not take eight clock edges");
    AST_IRQ_ENABLE: assert property (!ien_reg && !$past(ien_reg) |-> !o_irq)
        else $error("interrupt raised while disabled");
    AST_SLAVE_QUIET: assert property (i_ss_b [*6] ##0 (!o_sck_oe && !o_mosi_oe) |-> !o_miso_oe)
        else $error("miso driven while deselected");
    AST_PIN_DIR: assert property (o_miso_oe |-> !o_mosi_oe && !o_sck_oe && !o_ss_b_oe)
        else $error("pin directions of both modes at once");
    AST_ACK_CLEAR: assert property (i_irq_ack |-> ##[1:3] !o_irq)
        else $error("interrupt not cleared by acknowledge");
    AST_APB_READY: assert property (i_psel && i_penable |-> o_pready)
        else $error("access phase without ready");
endmodule : sps_port_sva

bind sps_port sps_port_sva sps_port_sva_inst (.i_mclk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .i_irq_ack, .o_irq, .i_ss_b, .o_sck, .o_sck_oe, .o_mosi,
    .o_mosi_oe, .o_miso_oe, .o_ss_b_oe);

// ===== bench/sps_far_slave.sv
// Far-side mode 0 slave, most significant bit first, one byte per select.
// Assumes the select line comes from the bench, since software owns it.
module sps_far_slave (
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_b,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic      [7:0] o_rx
);
    logic [7:0] sh = 8'h00;
    initial o_miso = 1'b0;
    initial o_rx = 8'h00;
    always @(negedge i_ss_b) begin
        sh = i_tx;
        o_miso = i_tx[7];
    end
    always @(posedge i_sck) if (!i_ss_b) o_rx <= {o_rx[6:0], i_mosi};
    always @(negedge i_sck) if (!i_ss_b) begin
        sh = {sh[6:0], 1'b0};
        o_miso = sh[7];
    end
    // A released line must not keep looking valid.
    always @(posedge i_ss_b) o_miso = ~o_miso;
endmodule : sps_far_slave

// ===== bench/tb_spi_master_slave_port.sv
// Testbench for the serial port: APB master, far slave and a pin driver.
// Assumes zero-wait APB answers and mode 0 traffic.
module tb_spi_master_slave_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic        ack = 1'b0;
    logic        b_sck = 1'b0;
    logic        b_mosi = 1'b0;
    logic        b_ss = 1'b1;
    logic        p_ss = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  p_tx = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd, prdata;
    logic [7:0]  p_rx, got;
    logic        pready, pslverr, irq, sck, sck_oe, mosi, mosi_oe;
    logic        miso, miso_oe, ss_oe, p_miso, err;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    sps_port sps_port_inst (.i_mclk(mclk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_irq_ack(ack), .o_irq(irq),
        .i_sck(b_sck), .i_mosi(b_mosi), .i_miso(p_miso), .i_ss_b(b_ss), .o_sck(sck),
        .o_sck_oe(sck_oe), .o_mosi(mosi), .o_mosi_oe(mosi_oe), .o_miso(miso),
        .o_miso_oe(miso_oe), .o_ss_b_oe(ss_oe));
    sps_far_slave sps_far_slave_inst (.i_sck(sck), .i_mosi(mosi), .i_ss_b(p_ss),
        .i_tx(p_tx), .o_miso(p_miso), .o_rx(p_rx));
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rdr
    task wait_done;
        for (int i = 0; i < 200; i++) begin
            rdr(sps_pkg::SPS_STAT_ADDR);
            if (rd[7] === 1'b1) break;
        end
    endtask : wait_done
    task xfer(input logic [7:0] tx, ptx, rx, prx, input logic use_ack);
        @(posedge mclk);
        p_tx <= ptx;
        p_ss <= 1'b0;
        wr(sps_pkg::SPS_DATA_ADDR, tx);
        if (use_ack) begin
            for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge mclk);
            chk("irq", irq, 1'b1);
            ack <= 1'b1;
            @(posedge mclk);
            ack <= 1'b0;
            repeat (3) @(posedge mclk);
            rdr(sps_pkg::SPS_STAT_ADDR);
            chk("done after ack", rd[7], 1'b0);
        end else begin
            wait_done();
            chk("done", rd[7], 1'b1);
            chk("irq", irq, 1'b1);
        end
        rdr(sps_pkg::SPS_DATA_ADDR);
        chk("rx byte", rd, {24'h0, rx});
        rdr(sps_pkg::SPS_STAT_ADDR);
        chk("flags", rd[7:6], 2'b00);
        chk("far rx", p_rx, prx);
        p_ss <= 1'b1;
    endtask : xfer
    // Pin driver acting as a master; each clock phase lasts six cycles.
    task sbyte(input logic [7:0] d, input int n);
        got = 8'h00;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            b_mosi <= d[7-i];
            repeat (5) @(posedge mclk);
            b_sck <= 1'b1;
            repeat (5) @(posedge mclk);
            got = {got[6:0], miso};
            @(posedge mclk);
            b_sck <= 1'b0;
        end
        repeat (8) @(posedge mclk);
    endtask : sbyte
    ////////////////////////////////////////////////////////////////////////
    task t_gate;
        rdr(sps_pkg::SPS_CTRL_ADDR);
        chk("ctrl reset", rd, 32'h0);
        rdr(sps_pkg::SPS_PWR_ADDR);
        chk("power reset", rd, 32'h1);
        rdr(8'h14);
        chk("unmapped", err, 1'b1);
        wr(sps_pkg::SPS_PINDIR_ADDR, 8'h0D);
        wr(sps_pkg::SPS_CTRL_ADDR, 8'hD1);
        wr(sps_pkg::SPS_DATA_ADDR, 8'h11);
        repeat (64) @(posedge mclk);
        rdr(sps_pkg::SPS_STAT_ADDR);
        chk("gated status", rd, 32'h0);
        wr(sps_pkg::SPS_PWR_ADDR, 8'h00);
        repeat (100) @(posedge mclk);
        rdr(sps_pkg::SPS_STAT_ADDR);
        rdr(sps_pkg::SPS_DATA_ADDR);
        $display("test gate done");
    endtask : t_gate
    task t_master;
        chk("miso oe", miso_oe, 1'b0);
        chk("mosi oe", mosi_oe, 1'b1);
        xfer(8'hA5, 8'h3C, 8'h3C, 8'hA5, 1'b0);
        xfer(8'h5A, 8'hC3, 8'hC3, 8'h5A, 1'b1);
        @(posedge mclk);
        p_tx <= 8'h3C;
        p_ss <= 1'b0;
        wr(sps_pkg::SPS_DATA_ADDR, 8'h81);
        wr(sps_pkg::SPS_DATA_ADDR, 8'h7E);
        wait_done();
        chk("collision", rd[7:0], 8'hC0);
        rdr(sps_pkg::SPS_DATA_ADDR);
        chk("rx kept", rd, 32'h3C);
        rdr(sps_pkg::SPS_STAT_ADDR);
        chk("flags cleared", rd, 32'h0);
        chk("far rx", p_rx, 8'h81);
        p_ss <= 1'b1;
        wr(sps_pkg::SPS_STAT_ADDR, 8'h01);
        wr(sps_pkg::SPS_CTRL_ADDR, 8'hF1);
        xfer(8'h03, 8'hE0, 8'h07, 8'hC0, 1'b0);
        $display("test master done");
    endtask : t_master
    task t_slave;
        wr(sps_pkg::SPS_STAT_ADDR, 8'h00);
        wr(sps_pkg::SPS_CTRL_ADDR, 8'hC0);
        wr(sps_pkg::SPS_PINDIR_ADDR, 8'h02);
        wr(sps_pkg::SPS_DATA_ADDR, 8'h96);
        chk("miso oe idle", miso_oe, 1'b0);
        sbyte(8'hFF, 8);
        rdr(sps_pkg::SPS_STAT_ADDR);
        chk("ignored", rd, 32'h0);
        b_ss <= 1'b0;
        sbyte(8'h69, 8);
        chk("miso oe", miso_oe, 1'b1);
        chk("slave tx", got, 8'h96);
        chk("slave irq", irq, 1'b1);
        rdr(sps_pkg::SPS_STAT_ADDR);
        chk("slave done", rd[7], 1'b1);
        wr(sps_pkg::SPS_DATA_ADDR, 8'h3A);
        rdr(sps_pkg::SPS_DATA_ADDR);
        chk("slave rx", rd, 32'h69);
        sbyte(8'hE0, 3);
        b_ss <= 1'b1;
        repeat (8) @(posedge mclk);
        rdr(sps_pkg::SPS_STAT_ADDR);
        chk("partial", rd, 32'h0);
        b_ss <= 1'b0;
        sbyte(8'h0F, 8);
        rdr(sps_pkg::SPS_STAT_ADDR);
        rdr(sps_pkg::SPS_DATA_ADDR);
        chk("resynced rx", rd, 32'h0F);
        b_ss <= 1'b1;
        $display("test slave done");
    endtask : t_slave
    task wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        t_gate();
        t_master();
        t_slave();
        wrap_up();
    end
endmodule : tb_spi_master_slave_port
